// ---- logic/xcss_pkg.sv ----
// Constants, register map and types of the crystal start-up select block
// Overview of operation
// - Upper select bits pick crystal frequency range
// - Class bit plus time field give delay
// - Class0 codes 00/01 wait 258 cycles
// - Codes 0/10, 0/11, 1/00 wait 1024 cycles
// - Class1 code 01 waits 16K, 14CK
// - Class1 code 10 waits 16K, plus 4.1ms
// - Class1 code 11 waits 16K, plus 65ms
// - Short-reset codes need reset pin enabled
// - Async timer may use low-frequency oscillator
// - Async timer starts low-frequency oscillator itself
// - Low-frequency codes 00/01 wait 1024 cycles
// - Low-frequency code 10 waits 32K cycles
// - Fuses copied into selection register one cycle after reset release
// - Watchdog cycles time the real-time delay
package xcss_pkg;
   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_CLKSEL = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   // Selection register field positions
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned SRC_W = 4;
   localparam int unsigned SUT_LSB = 4;
   localparam int unsigned SUT_W = 2;
   // Control register bits
   localparam int unsigned CTRL_WAKE_BIT = 0;
   // Status register bits
   localparam int unsigned ST_READY_BIT = 0;
   localparam int unsigned ST_BUSY_BIT = 1;
   localparam int unsigned ST_RSVD_BIT = 2;
   localparam int unsigned ST_UNAV_BIT = 3;
   localparam int unsigned ST_LFGR_BIT = 4;
   localparam int unsigned ST_FUSE_BAD_BIT = 5;
   // Source codes: top two bits 01 is low-frequency crystal, top bit 1 is crystal
   localparam logic [1:0] SRC_LF_TOP = 2'h1;
   localparam logic [2:0] RANGE_0P4_0P9 = 3'h4;
   localparam logic [2:0] RANGE_0P9_3P0 = 3'h5;
   localparam logic [2:0] RANGE_3P0_8P0 = 3'h6;
   localparam logic [2:0] RANGE_8P0_16P0 = 3'h7;
   // Start-up time codes
   localparam logic [1:0] SUT_00 = 2'h0;
   localparam logic [1:0] SUT_01 = 2'h1;
   localparam logic [1:0] SUT_10 = 2'h2;
   localparam logic [1:0] SUT_11 = 2'h3;
   // Oscillator cycle counts that stay below the parameter threshold
   localparam int unsigned CNT_W = 16;
   localparam logic [15:0] CK_258 = 16'h0102;
   localparam logic [15:0] CK_1K = 16'h0400;
   localparam logic [15:0] CK_RST_14 = 16'h000E;
   localparam logic [15:0] CK_NONE = 16'h0000;
   // Real-time part of the reset delay, in microseconds
   localparam int unsigned T_SHORT_US = 4100;
   localparam int unsigned T_LONG_US = 65000;
   // Watchdog cycles for the short time-out
   localparam logic [15:0] WDT_SHORT_CYC = 16'h0200;
   // Fuse bits: a programmed fuse reads 0
   localparam logic FUSE_PROGRAMMED = 1'b0;
   // Decoded start-up timing for one selection
   typedef struct packed {
      logic valid;
      logic reserved;
      logic is_hf;
      logic is_lf;
      logic [15:0] pd_ck;
      logic [15:0] rst_ck;
      logic [15:0] wdt_cyc;
   } xcss_timing_t;
endpackage : xcss_pkg

// ---- logic/xcss_cycle_counter.sv ----
// Tick counter that signals when a latched limit of ticks has elapsed
`timescale 1ns/1ps
`default_nettype none
module xcss_cycle_counter
   import xcss_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic [15:0] limit,
   input wire logic tick,
   // Result
   output logic done,
   output logic running
);
   logic [15:0] cnt_q; // Ticks seen since start
   logic [15:0] lim_q; // Limit latched at start
   logic run_q; // Count in progress
   logic done_q; // Limit reached, held until next start

   // Latch limit and count ticks; a zero limit completes at once
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_q <= CK_NONE;
         lim_q <= CK_NONE;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (start)
      begin
         // Fresh count clears the done flag, or sets it at once when the limit is zero
         cnt_q <= CK_NONE;
         lim_q <= limit;
         run_q <= (limit != CK_NONE);
         done_q <= (limit == CK_NONE);
      end
      else if (run_q && tick)
      begin
         // Count one oscillator cycle
         cnt_q <= 16'(cnt_q + 16'h0001);
         if (cnt_q + 16'h0001 == lim_q)
         begin
            run_q <= 1'b0;
            done_q <= 1'b1;
         end
      end
   end

   assign done = done_q;
   assign running = run_q;
endmodule // xcss_cycle_counter
`default_nettype wire

// ---- logic/xcss_startup_ctrl.sv ----
// Start-up delay sequencer and selection register for the crystal oscillators
`timescale 1ns/1ps
`default_nettype none
module xcss_startup_ctrl
   import xcss_pkg::*;
#(
   // Long oscillator and watchdog counts, shortenable for simulation
   parameter logic [15:0] XTAL_LONG_CK = 16'h4000,
   parameter logic [15:0] LF_LONG_CK = 16'h8000,
   parameter logic [15:0] WDT_LONG_CYC = 16'h2000
)
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Fuse values
   input wire logic [2:0] RANGE_SELECT_FUSES,
   input wire logic STARTUP_CLASS_FUSE,
   input wire logic [1:0] STARTUP_TIME_FUSES,
   input wire logic RESET_PIN_DISABLE_FUSE,
   // Oscillator cycle pulses, one SYS_CLK wide each
   input wire logic OSC_TICK,
   input wire logic WDT_TICK,
   // Power management and neighbouring clock users
   input wire logic WAKE_REQ,
   input wire logic EXT_CLK_EN,
   input wire logic ASYNC_TMR_REQ,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   output logic [31:0] REG_RDATA,
   // Clock control outputs
   output logic CORE_CLK_EN,
   output logic HF_OSC_EN,
   output logic LF_OSC_EN,
   output logic ASYNC_LF_GRANT
);
   // Sequencer states
   typedef enum logic [2:0] {
      S_LOAD,
      S_DECIDE,
      S_RWDT,
      S_ROSC,
      S_WAKE,
      S_READY,
      S_HALT
   } xcss_state_t;

   xcss_state_t state_q; // Current sequencer state
   xcss_state_t state_d; // Next sequencer state
   logic [3:0] src_q; // Source-select field of the selection register
   logic [1:0] sut_q; // Start-up time field of the selection register
   logic [31:0] rdata_q; // Read data, valid the cycle after a read
   xcss_timing_t cur_t; // Timing decoded from the register
   xcss_timing_t fuse_t; // Timing decoded from the fuses
   logic wake_sw; // Software wake request
   logic wake_any; // Any wake request
   logic cnt_start; // Counter start pulse
   logic [15:0] cnt_limit; // Limit for the counter
   logic cnt_tick; // Tick routed to the counter
   logic cnt_done; // Counter reached limit
   logic cnt_run; // Counter busy
   logic lf_permit; // Async timer may use the low-frequency oscillator
   logic [15:0] ck_pd_rst; // Oscillator cycles for the reset path

   // Decode one selection into start-up timing
   function automatic xcss_timing_t decode_timing(input logic [3:0] src, input logic [1:0] sut,
                                                  input logic rst_pin_off);
      xcss_timing_t t;
      t = '0;
      if (src[3])
      begin
         // Crystal range is src[3:1]; class bit and time field choose delay
         t.is_hf = 1'b1;
         t.valid = 1'b1;
         case ({src[0], sut})
            {1'b0, SUT_00}:
            begin
               t.pd_ck = CK_258;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = WDT_SHORT_CYC;
            end
            {1'b0, SUT_01}:
            begin
               t.pd_ck = CK_258;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = WDT_LONG_CYC;
            end
            {1'b0, SUT_10}:
            begin
               t.pd_ck = CK_1K;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = CK_NONE;
               t.valid = (rst_pin_off != FUSE_PROGRAMMED);
            end
            {1'b0, SUT_11}:
            begin
               t.pd_ck = CK_1K;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = WDT_SHORT_CYC;
            end
            {1'b1, SUT_00}:
            begin
               t.pd_ck = CK_1K;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = WDT_LONG_CYC;
            end
            {1'b1, SUT_01}:
            begin
               t.pd_ck = XTAL_LONG_CK;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = CK_NONE;
               t.valid = (rst_pin_off != FUSE_PROGRAMMED);
            end
            {1'b1, SUT_10}:
            begin
               t.pd_ck = XTAL_LONG_CK;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = WDT_SHORT_CYC;
            end
            default:
            begin
               t.pd_ck = XTAL_LONG_CK;
               t.rst_ck = CK_RST_14;
               t.wdt_cyc = WDT_LONG_CYC;
            end
         endcase
      end
      else if (src[3:2] == SRC_LF_TOP)
      begin
         // Low-frequency crystal: no fixed cycle part in the reset delay
         t.is_lf = 1'b1;
         t.valid = 1'b1;
         t.rst_ck = CK_NONE;
         case (sut)
            SUT_00:
            begin
               t.pd_ck = CK_1K;
               t.wdt_cyc = WDT_SHORT_CYC;
            end
            SUT_01:
            begin
               t.pd_ck = CK_1K;
               t.wdt_cyc = WDT_LONG_CYC;
            end
            SUT_10:
            begin
               t.pd_ck = LF_LONG_CK;
               t.wdt_cyc = WDT_LONG_CYC;
            end
            default:
            begin
               // Reserved code: no delay is defined, sequencer refuses it
               t.reserved = 1'b1;
               t.valid = 1'b0;
            end
         endcase
      end
      return t;
   endfunction

   // Live decode of the register and of the raw fuses
   assign cur_t = decode_timing(src_q, sut_q, RESET_PIN_DISABLE_FUSE);
   assign fuse_t = decode_timing({RANGE_SELECT_FUSES, STARTUP_CLASS_FUSE}, STARTUP_TIME_FUSES,
                                 RESET_PIN_DISABLE_FUSE);

   // Software wake request from the control register
   assign wake_sw = REG_WE && (REG_ADDR == OFS_CTRL) && REG_WDATA[CTRL_WAKE_BIT];
   assign wake_any = WAKE_REQ || wake_sw;

   // Selection register: fuse copy after reset, then software writes
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         src_q <= 4'h0;
         sut_q <= SUT_00;
      end
      else if (state_q == S_LOAD)
      begin
         // Fuse copy taken by a clocked process after reset release
         src_q <= {RANGE_SELECT_FUSES, STARTUP_CLASS_FUSE};
         sut_q <= STARTUP_TIME_FUSES;
      end
      else if (REG_WE && (REG_ADDR == OFS_CLKSEL))
      begin
         src_q <= REG_WDATA[SRC_LSB +: SRC_W];
         sut_q <= REG_WDATA[SUT_LSB +: SUT_W];
      end
   end

   // Read data register; unmapped addresses read zero
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (REG_RE)
      begin
         rdata_q <= 32'h0000_0000;
         case (REG_ADDR)
            OFS_CLKSEL:
            begin
               rdata_q[SRC_LSB +: SRC_W] <= src_q;
               rdata_q[SUT_LSB +: SUT_W] <= sut_q;
            end
            OFS_STATUS:
            begin
               rdata_q[ST_READY_BIT] <= (state_q == S_READY);
               rdata_q[ST_BUSY_BIT] <= cnt_run;
               rdata_q[ST_RSVD_BIT] <= cur_t.reserved;
               rdata_q[ST_UNAV_BIT] <= !cur_t.valid;
               rdata_q[ST_LFGR_BIT] <= ASYNC_LF_GRANT;
               rdata_q[ST_FUSE_BAD_BIT] <= !fuse_t.valid;
            end
            default:
            begin
               // Control register is write-only, others unmapped
               rdata_q <= 32'h0000_0000;
            end
         endcase
      end
      else
      begin
         // Data stand only in the cycle after the read
         rdata_q <= 32'h0000_0000;
      end
   end

   // Reset path oscillator count: wake-up cycles plus fixed reset cycles
   assign ck_pd_rst = 16'(cur_t.pd_ck + cur_t.rst_ck);

   // Next-state logic of the start-up sequencer
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         S_LOAD:
         begin
            state_d = S_DECIDE;
         end
         S_DECIDE:
         begin
            // Real-time part first, skipped when none is selected
            if (!cur_t.valid)
               state_d = S_HALT;
            else if (cur_t.wdt_cyc != CK_NONE)
               state_d = S_RWDT;
            else
               state_d = S_ROSC;
         end
         S_RWDT:
         begin
            if (cnt_done)
               state_d = S_ROSC;
         end
         S_ROSC, S_WAKE:
         begin
            if (cnt_done)
               state_d = S_READY;
         end
         S_READY, S_HALT:
         begin
            // Wake from power-down or re-check on software request
            if (wake_any)
               state_d = cur_t.valid ? S_WAKE : S_HALT;
         end
         default:
         begin
            state_d = S_LOAD;
         end
      endcase
   end

   // State register
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
         state_q <= S_LOAD;
      else
         state_q <= state_d;
   end

   // Counter is started on entry to each counting state
   assign cnt_start = (state_d != state_q) &&
                      ((state_d == S_RWDT) || (state_d == S_ROSC) || (state_d == S_WAKE));

   // Limit and tick source for the counter
   always_comb
   begin
      cnt_limit = cur_t.pd_ck;
      cnt_tick = OSC_TICK;
      case (state_d)
         S_RWDT:
         begin
            cnt_limit = cur_t.wdt_cyc;
         end
         S_ROSC:
         begin
            cnt_limit = ck_pd_rst;
         end
         default:
         begin
            cnt_limit = cur_t.pd_ck;
         end
      endcase
      // Watchdog oscillator times the real-time part of the reset delay
      if (state_q == S_RWDT)
         cnt_tick = WDT_TICK;
   end

   // Shared start-up counter
   xcss_cycle_counter u_counter (
      .clk(SYS_CLK),
      .rst(RST),
      .start(cnt_start),
      .limit(cnt_limit),
      .tick(cnt_tick),
      .done(cnt_done),
      .running(cnt_run)
   );

   // Core clock held off until the selected count has elapsed
   assign CORE_CLK_EN = (state_q == S_READY);

   // High-frequency amplifier runs when a crystal range is selected
   assign HF_OSC_EN = cur_t.is_hf && (state_q != S_LOAD);

   // Async timer may take the low-frequency oscillator only when pins are free
   assign lf_permit = !HF_OSC_EN && !EXT_CLK_EN;
   assign ASYNC_LF_GRANT = ASYNC_TMR_REQ && lf_permit;

   // Low-frequency oscillator on as system source or for the async timer
   assign LF_OSC_EN = (cur_t.is_lf && (state_q != S_LOAD)) || ASYNC_LF_GRANT;

   assign REG_RDATA = rdata_q;

   // Core clock never enabled while a count is in progress
   a_gate_while_count: assert property (@(posedge SYS_CLK) disable iff (RST)
      cnt_run |-> !CORE_CLK_EN)
      else $error("core clock enabled during start-up count");

   // Fuses reach the register one cycle after reset release
   a_fuse_copy: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_q == S_LOAD) |=> (src_q == $past({RANGE_SELECT_FUSES, STARTUP_CLASS_FUSE})) &&
                               (sut_q == $past(STARTUP_TIME_FUSES)))
      else $error("fuse values not copied into selection register");

   // Short-reset crystal codes refused while reset pin is disabled
   a_short_refused: assert property (@(posedge SYS_CLK) disable iff (RST)
      (src_q[3] && (RESET_PIN_DISABLE_FUSE == FUSE_PROGRAMMED) &&
       ({src_q[0], sut_q} == {1'b0, SUT_10} || {src_q[0], sut_q} == {1'b1, SUT_01})) |-> !cur_t.valid)
      else $error("short reset setting accepted with reset pin disabled");

   // Reserved low-frequency code never starts a count
   a_lf_reserved: assert property (@(posedge SYS_CLK) disable iff (RST)
      ((src_q[3:2] == SRC_LF_TOP) && (sut_q == SUT_11)) |-> !cnt_start)
      else $error("reserved low-frequency code started a count");

   // Short crystal wake-up uses 258 cycles
   a_xtal_258: assert property (@(posedge SYS_CLK) disable iff (RST)
      (cnt_start && (state_d == S_WAKE) && src_q[3] && !src_q[0] && !sut_q[1]) |-> (cnt_limit == CK_258))
      else $error("wrong short crystal wake-up count");

   // Long crystal wake-up uses the 16K count
   a_xtal_16k: assert property (@(posedge SYS_CLK) disable iff (RST)
      (cnt_start && (state_d == S_WAKE) && src_q[3] && src_q[0] && (sut_q != SUT_00))
      |-> (cnt_limit == XTAL_LONG_CK))
      else $error("wrong long crystal wake-up count");

   // Low-frequency code 10 wakes after the 32K count
   a_lf_32k: assert property (@(posedge SYS_CLK) disable iff (RST)
      (cnt_start && (state_d == S_WAKE) && (src_q[3:2] == SRC_LF_TOP) && (sut_q == SUT_10))
      |-> (cnt_limit == LF_LONG_CK))
      else $error("wrong low-frequency long wake-up count");

   // Watchdog phase counts watchdog ticks only
   a_wdt_tick: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_q == S_RWDT) |-> (cnt_tick == WDT_TICK))
      else $error("reset real-time phase not timed by watchdog");

   // Grant withdrawn in the same cycle as the high-frequency crystal starts
   a_lf_grant: assert property (@(posedge SYS_CLK) disable iff (RST)
      $rose(HF_OSC_EN) |-> !ASYNC_LF_GRANT ##1 (!HF_OSC_EN || !ASYNC_LF_GRANT))
      else $error("async timer granted low-frequency oscillator while pins busy");

   // Async request alone starts the low-frequency oscillator when permitted
   a_lf_self_start: assert property (@(posedge SYS_CLK) disable iff (RST)
      (ASYNC_TMR_REQ && !HF_OSC_EN && !EXT_CLK_EN) |-> LF_OSC_EN)
      else $error("async timer could not start low-frequency oscillator");

   // Read data stand one cycle only
   a_read_one_cycle: assert property (@(posedge SYS_CLK) disable iff (RST)
      (!REG_RE ##1 !REG_RE) |=> (REG_RDATA == 32'h0000_0000))
      else $error("read data held beyond one cycle");
endmodule // xcss_startup_ctrl
`default_nettype wire

// ---- testbench/xcss_osc_model.sv ----
// Behavioural crystal or resonator beside the free-running watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module xcss_osc_model
(
   // Clock
   input wire logic clk,
   // Amplifier enables from the block
   input wire logic hf_on,
   input wire logic lf_on,
   // Cumulative tick budgets granted by the bench
   input var int osc_allow,
   input var int wdt_allow,
   // Oscillator cycles as one-clock pulses
   output var logic osc_tick = 1'b0,
   output var logic wdt_tick = 1'b0,
   // Ticks sent so far
   output var int osc_sent = 0,
   output var int wdt_sent = 0
);
   // Divider phase: at most one tick every second clock
   logic ph = 1'b0;
   // Resonator swings only while its amplifier is powered
   always @(posedge clk)
   begin
      ph <= ~ph;
      osc_tick <= ph && (hf_on || lf_on) && osc_sent < osc_allow;
      if (ph && (hf_on || lf_on) && osc_sent < osc_allow)
         osc_sent <= osc_sent + 1;
      // Watchdog oscillator runs regardless of the selection
      wdt_tick <= ph && wdt_sent < wdt_allow;
      if (ph && wdt_sent < wdt_allow)
         wdt_sent <= wdt_sent + 1;
   end
endmodule // xcss_osc_model
`default_nettype wire

// ---- testbench/xcss_startup_ctrl_tb_top.sv ----
// Self-checking bench for the crystal start-up select block
`timescale 1ns/1ps
`default_nettype none
module xcss_startup_ctrl_tb_top
   import xcss_pkg::*;
;
   // Stimulus and observed signals
   logic clk = 1'b0, rst = 1'b1, cls_f = 1'b0, rpd_f = 1'b1, wake = 1'b0;
   logic ext_en = 1'b0, tmr_req = 1'b0, we = 1'b0, re = 1'b0;
   logic [2:0] rng_f = 3'h0;
   logic [1:0] sut_f = 2'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic osc_tick, wdt_tick, core_en, hf_en, lf_en, grant;
   int osc_allow = 0, wdt_allow = 0, osc_sent, wdt_sent, bad_count = 0, checks_done = 0;
   // Crystal wake counts and watchdog counts per class/time index
   int pd_x[8] = '{258, 258, 1024, 1024, 1024, 40, 40, 40};
   int wd_x[8] = '{512, 30, 0, 512, 30, 0, 512, 30};
   // System clock, 100 ns period
   initial
   begin
      forever #50 clk = ~clk;
   end
   // Block under test with shortened long counts
   xcss_startup_ctrl #(.XTAL_LONG_CK(16'h0028), .LF_LONG_CK(16'h0032), .WDT_LONG_CYC(16'h001E)) uut (
      .SYS_CLK(clk), .RST(rst), .RANGE_SELECT_FUSES(rng_f), .STARTUP_CLASS_FUSE(cls_f),
      .STARTUP_TIME_FUSES(sut_f), .RESET_PIN_DISABLE_FUSE(rpd_f), .OSC_TICK(osc_tick),
      .WDT_TICK(wdt_tick), .WAKE_REQ(wake), .EXT_CLK_EN(ext_en), .ASYNC_TMR_REQ(tmr_req),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
      .CORE_CLK_EN(core_en), .HF_OSC_EN(hf_en), .LF_OSC_EN(lf_en), .ASYNC_LF_GRANT(grant));
   // Far-side oscillators
   xcss_osc_model osc (.clk(clk), .hf_on(hf_en), .lf_on(lf_en), .osc_allow(osc_allow),
      .wdt_allow(wdt_allow), .osc_tick(osc_tick), .wdt_tick(wdt_tick), .osc_sent(osc_sent),
      .wdt_sent(wdt_sent));
   // Compare one value and count it
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Grant n more ticks of one oscillator, wait for them, then let the block settle
   task automatic give(input bit wd, input int n);
      int lim;
      lim = 0;
      @(posedge clk);
      if (wd)
         wdt_allow <= wdt_allow + n;
      else
         osc_allow <= osc_allow + n;
      @(posedge clk);
      while ((wd ? wdt_sent != wdt_allow : osc_sent != osc_allow) && lim < 20000)
      begin
         @(posedge clk);
         lim++;
      end
      // A stuck oscillator ends the run
      if (lim == 20000)
      begin
         bad_count++;
         final_report();
      end
      else
      begin
         repeat (5) @(posedge clk);
         #1;
      end
   endtask
   // Core clock must appear on the last tick and not one tick before
   task automatic startup(input int w, input int t);
      if (w > 0)
      begin
         give(1'b1, w - 1);
         give(1'b0, t);
         chk("core enable in watchdog phase", 32'h0, {31'h0, core_en});
         give(1'b1, 1);
      end
      give(1'b0, t - 1);
      chk("core enable before last tick", 32'h0, {31'h0, core_en});
      give(1'b0, 1);
      chk("core enable after count", 32'h1, {31'h0, core_en});
   endtask
   // Load fuses and pass through a 16-cycle reset
   task automatic reset_to(input logic [2:0] r, input logic c, input logic [1:0] s, input logic p);
      @(posedge clk);
      rst <= 1'b1;
      rng_f <= r;
      cls_f <= c;
      sut_f <= s;
      rpd_f <= p;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Power-down exit request
   task automatic wake_req();
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("core enable after wake", 32'h0, {31'h0, core_en});
   endtask
   // Register write and read cycles
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
      #1;
   endtask
   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1;
      rd = rdata;
   endtask
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      // Crystal table, all four ranges touched on the way
      for (int i = 0; i < 8; i++)
      begin
         reset_to(3'(4 + i % 4), i[2], i[1:0], 1'b1);
         reg_rd(OFS_CLKSEL);
         chk("selection register", {26'h0, i[1:0], 3'(4 + i % 4), i[2]}, rd);
         chk("oscillator enables", 32'h2, {30'h0, hf_en, lf_en});
         startup(wd_x[i], pd_x[i] + 14);
         wake_req();
         startup(0, pd_x[i]);
      end
      $display("test crystal table done");
      // Low-frequency crystal codes
      for (int j = 0; j < 3; j++)
      begin
         reset_to(3'h2, 1'b0, j[1:0], 1'b1);
         chk("oscillator enables", 32'h1, {30'h0, hf_en, lf_en});
         startup(j == 0 ? 512 : 30, j == 2 ? 50 : 1024);
         wake_req();
         startup(0, j == 2 ? 50 : 1024);
      end
      $display("test low-frequency table done");
      // Reserved low-frequency code halts
      reset_to(3'h2, 1'b0, 2'h3, 1'b1);
      give(1'b1, 600);
      reg_rd(OFS_STATUS);
      chk("status reserved code", 32'h0C, rd & 32'h0D);
      // Short-reset settings with the reset pin disabled
      for (int k = 0; k < 2; k++)
      begin
         reset_to(3'h7, k[0], k == 1 ? 2'h1 : 2'h2, 1'b0);
         give(1'b1, 600);
         reg_rd(OFS_STATUS);
         chk("status unusable fuse setting", 32'h28, rd & 32'h29);
      end
      $display("test refused settings done");
      // Async timer access to the low-frequency oscillator
      @(posedge clk);
      tmr_req <= 1'b1;
      @(posedge clk);
      #1;
      chk("grant with crystal on", 32'h0, {31'h0, grant});
      reg_wr(OFS_CLKSEL, 32'h02);
      chk("grant and lf enable", 32'h3, {30'h0, grant, lf_en});
      reg_rd(OFS_STATUS);
      chk("status grant", 32'h10, rd & 32'h10);
      @(posedge clk);
      ext_en <= 1'b1;
      @(posedge clk);
      #1;
      chk("grant with external clock", 32'h0, {31'h0, grant});
      @(posedge clk);
      tmr_req <= 1'b0;
      ext_en <= 1'b0;
      reg_rd(8'h0C);
      chk("unmapped read", 32'h0, rd);
      $display("test async grant done");
      // Software reselect and recount through the control register
      reset_to(3'h6, 1'b1, 2'h1, 1'b1);
      startup(0, 54);
      reg_wr(OFS_CLKSEL, 32'h0E);
      reg_rd(OFS_CLKSEL);
      chk("selection written", 32'h0E, rd);
      reg_wr(OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk("core enable after recount request", 32'h0, {31'h0, core_en});
      startup(0, 258);
      $display("test software recount done");
      final_report();
   end
endmodule // xcss_startup_ctrl_tb_top
`default_nettype wire
